// ### design/chid_regs.sv
/*
 * Chip identification and timer hold register group, top level.
 * Holds the AHB-Lite slave, the read/write control bits and the read mux,
 * and instantiates the identification bytes and the timer hold core.
 * Assumes a single AHB-Lite master issuing single word transfers on hclk.
 */
// Contract
// - Third type character byte, read only
// - Compatibility code low nibble, upper reserved
// - Revision letter byte, read only
// - Set bit 3 holds watchdog unless reset-only
// - Set bits 2..0 hold radio, software, wakeup
// - Clear register ones resume matching timers
// - Debug enable holds all timers when halted
// - Enable low: halted radio, software, wakeup holds follow software state
// - Watchdog always held during debug halt
// - Status bit 0 calibration flag, reset zero
// - Reset-only watchdog ignores software hold
`timescale 1ns/100ps
module chid_regs #(
    parameter logic [7:0] CHAR3_VALUE = 8'h39, // Arbitrary value
    parameter logic [3:0] SWC_VALUE   = 4'h0,
    parameter logic [7:0] REV_VALUE   = 8'h43  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output      logic        hreadyout,
    output      logic        hresp,
    output      logic [31:0] hrdata,
    // System status inputs
    input  wire logic        wdog_reset_only,
    input  wire logic        cpu_debug_halted,
    // Timer hold outputs
    output      logic        hold_watchdog,
    output      logic        hold_radio_master_clock,
    output      logic        hold_software_timer,
    output      logic        hold_wakeup_timer,
    // Control bits
    output      logic        debug_halt_hold_enable,
    output      logic        cal_phase_flag
);

    typedef struct packed {
        chid_pkg::chid_sel_t sel;
        logic                wr_pend;
        logic                rd_pend;
        logic                ready;
        logic                resp;
        logic [31:0]         rdata;
        logic                dbg_en;
        logic                cal;
    } chid_top_st_t;

    chid_top_st_t st_ff;
    chid_top_st_t nxt_st;

    logic [7:0] id_char3;
    logic [7:0] id_swc;
    logic [7:0] id_rev;
    logic       accept;
    logic       wr_data;

    chid_hold_if hif ();

    // Fixed identification bytes
    chid_id_regs #(
        .CHAR3 (CHAR3_VALUE),
        .SWC   (SWC_VALUE),
        .REV   (REV_VALUE)
    ) u_id (
        .hclk    (hclk),
        .hresetn (hresetn),
        .char3   (id_char3),
        .swc     (id_swc),
        .rev     (id_rev)
    );

    // Software and debug hold logic
    chid_hold_core u_core (
        .hclk    (hclk),
        .hresetn (hresetn),
        .hif     (hif)
    );

    // A transfer is taken only when selected, active, word sized and the bus is ready
    assign accept  = hsel && htrans[1] && hready && (hsize == chid_pkg::HSIZE_WORD);
    assign wr_data = st_ff.wr_pend;

    // Hold masks go to the core in the write data phase, so that a read that
    // follows at once already sees the new state in its wait cycle
    always_comb begin
        hif.set_req    = (wr_data && st_ff.sel == chid_pkg::SEL_HSET) ? hwdata[3:0] : 4'h0;
        hif.clr_req    = (wr_data && st_ff.sel == chid_pkg::SEL_HCLR) ? hwdata[3:0] : 4'h0;
        hif.dbg_en     = st_ff.dbg_en;
        hif.halted     = cpu_debug_halted;
        hif.reset_only = wdog_reset_only;
    end

    // Read mux; unmapped addresses and reserved bits read as zero
    function automatic logic [31:0] read_value(input chid_pkg::chid_sel_t sel,
                                               input logic [3:0]          sw,
                                               input logic                dbg,
                                               input logic                cal);
        case (sel)
            chid_pkg::SEL_CHAR3: read_value = {24'h000000, id_char3};
            chid_pkg::SEL_SWC:   read_value = {24'h000000, id_swc};
            chid_pkg::SEL_REV:   read_value = {24'h000000, id_rev};
            chid_pkg::SEL_HSET:  read_value = {28'h0000000, sw};
            chid_pkg::SEL_HCLR:  read_value = {28'h0000000, sw};
            chid_pkg::SEL_DBG:   read_value = {31'h00000000, dbg};
            chid_pkg::SEL_STAT:  read_value = {31'h00000000, cal};
            default:             read_value = 32'h00000000;
        endcase
    endfunction : read_value

    // Bus state machine: writes complete with no wait state, reads take one
    // wait cycle so that the answer comes from a register
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.resp    = 1'b0;
        nxt_st.wr_pend = 1'b0;
        nxt_st.rd_pend = 1'b0;
        nxt_st.ready   = 1'b1;

        // Data phase of a write: store control bits
        if (wr_data) begin
            if (st_ff.sel == chid_pkg::SEL_DBG) begin
                nxt_st.dbg_en = hwdata[0];
            end
            if (st_ff.sel == chid_pkg::SEL_STAT) begin
                nxt_st.cal = hwdata[0];
            end
        end

        // Wait cycle of a read: capture the answer
        if (st_ff.rd_pend) begin
            nxt_st.rdata = read_value(st_ff.sel, hif.sw_state, st_ff.dbg_en, st_ff.cal);
        end

        // Address phase
        if (accept) begin
            nxt_st.sel     = chid_pkg::chid_decode(haddr);
            nxt_st.wr_pend = hwrite;
            nxt_st.rd_pend = !hwrite;
            nxt_st.ready   = hwrite;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff.sel     <= chid_pkg::SEL_NONE;
            st_ff.wr_pend <= 1'b0;
            st_ff.rd_pend <= 1'b0;
            st_ff.ready   <= 1'b1;
            st_ff.resp    <= 1'b0;
            st_ff.rdata   <= 32'h00000000;
            st_ff.dbg_en  <= chid_pkg::DBG_RST;
            st_ff.cal     <= chid_pkg::STAT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from flip-flops here or in the core
    assign hreadyout               = st_ff.ready;
    assign hresp                   = st_ff.resp;
    assign hrdata                  = st_ff.rdata;
    assign debug_halt_hold_enable  = st_ff.dbg_en;
    assign cal_phase_flag          = st_ff.cal;
    assign hold_watchdog           = hif.hold[chid_pkg::HOLD_WDOG_BIT];
    assign hold_radio_master_clock = hif.hold[chid_pkg::HOLD_RADIO_BIT];
    assign hold_software_timer     = hif.hold[chid_pkg::HOLD_SWTIM_BIT];
    assign hold_wakeup_timer       = hif.hold[chid_pkg::HOLD_WKUP_BIT];

    // Identification reads return the fixed bytes, zero above
    char3_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.rd_pend && st_ff.sel == chid_pkg::SEL_CHAR3 |=> hreadyout && hrdata == {24'h000000, CHAR3_VALUE})
        else $error("third type character read wrong");
    swc_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.rd_pend && st_ff.sel == chid_pkg::SEL_SWC |=> hrdata == {28'h0000000, SWC_VALUE})
        else $error("compatibility code read wrong");
    rev_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.rd_pend && st_ff.sel == chid_pkg::SEL_REV |=> hrdata == {24'h000000, REV_VALUE})
        else $error("revision letter read wrong");

    // A write to the set register reaches the watchdog hold two edges later
    set_to_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_data && st_ff.sel == chid_pkg::SEL_HSET && hwdata[3] && !wdog_reset_only ##1 !wdog_reset_only
        |=> hold_watchdog)
        else $error("watchdog hold write had no effect");

    // A write of zeros to the set register changes no hold state
    set_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_data && st_ff.sel == chid_pkg::SEL_HSET && hwdata[3:0] == 4'h0 |=> $stable(hif.sw_state))
        else $error("zero write changed hold state");

    // A clear write resumes the matching timers
    clr_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_data && st_ff.sel == chid_pkg::SEL_HCLR |=> (hif.sw_state & $past(hwdata[3:0])) == 4'h0)
        else $error("clear write left a timer held");

    // Debug enable and calibration flag follow the written bit
    dbg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_data && st_ff.sel == chid_pkg::SEL_DBG |=> debug_halt_hold_enable == $past(hwdata[0]))
        else $error("debug hold enable not written");
    cal_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_data && st_ff.sel == chid_pkg::SEL_STAT |=> cal_phase_flag == $past(hwdata[0]))
        else $error("calibration flag not written");
    cal_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.rd_pend && st_ff.sel == chid_pkg::SEL_STAT |=> hrdata == {31'h00000000, $past(st_ff.cal)})
        else $error("status read wrong");

    // Reads always answer after exactly one wait cycle
    read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_nowait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && hwrite |=> hreadyout)
        else $error("write inserted a wait state");
    resp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !hresp)
        else $error("error response seen");

    // A refused size leaves the bus idle, so nothing is stored later
    size_skip_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && htrans[1] && hready && hsize != chid_pkg::HSIZE_WORD
        |=> hreadyout && !st_ff.wr_pend && !st_ff.rd_pend)
        else $error("non-word transfer taken");

    // Read data stand until the next read captures new ones
    none_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.rd_pend && st_ff.sel == chid_pkg::SEL_NONE |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    rdata_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !st_ff.rd_pend |=> $stable(hrdata))
        else $error("read data changed without a read");
    hset_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.rd_pend && st_ff.sel == chid_pkg::SEL_HSET |=> hrdata == {28'h0000000, $past(hif.sw_state)})
        else $error("hold set read wrong");
    hclr_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.rd_pend && st_ff.sel == chid_pkg::SEL_HCLR |=> hrdata == {28'h0000000, $past(hif.sw_state)})
        else $error("hold clear read wrong");
    dbg_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.rd_pend && st_ff.sel == chid_pkg::SEL_DBG |=> hrdata == {31'h00000000, $past(st_ff.dbg_en)})
        else $error("debug enable read wrong");

    // Control bits change only through their own write
    dbg_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(wr_data && st_ff.sel == chid_pkg::SEL_DBG) |=> $stable(debug_halt_hold_enable))
        else $error("debug enable changed unwritten");
    cal_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(wr_data && st_ff.sel == chid_pkg::SEL_STAT) |=> $stable(cal_phase_flag))
        else $error("calibration flag changed unwritten");

    // Hold pins seen from outside, one edge after their causes
    wdog_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wdog_reset_only && !cpu_debug_halted |=> hold_watchdog == $past(hif.sw_state[3]))
        else $error("watchdog hold pin wrong");
    halt_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cpu_debug_halted |=> hold_watchdog)
        else $error("watchdog pin free in debug halt");
    ro_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wdog_reset_only && !cpu_debug_halted |=> !hold_watchdog)
        else $error("reset-only watchdog pin held");
    radio_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !cpu_debug_halted |=> hold_radio_master_clock == $past(hif.sw_state[2]))
        else $error("radio clock hold pin wrong");

endmodule : chid_regs

// ### design/chid_pkg.sv
/*
 * Package for the chip identification and timer hold register group:
 * register indices, field positions, reset values and the decode helpers.
 * Assumes a 32-bit AHB-Lite bus in which each register takes one aligned word.
 */
package chid_pkg;

    // Printed register offsets are indices, not byte addresses
    localparam logic [31:0] CHAR3_IDX   = 32'h5000_3202;
    localparam logic [31:0] SWC_IDX     = 32'h5000_3203;
    localparam logic [31:0] REV_IDX     = 32'h5000_3204;
    localparam logic [31:0] HSET_IDX    = 32'h5000_3300;
    localparam logic [31:0] HCLR_IDX    = 32'h5000_3302;
    localparam logic [31:0] DBG_IDX     = 32'h5000_3304;
    localparam logic [31:0] STAT_IDX    = 32'h5000_3306;

    // Hold mask bit positions, shared by the set and clear registers
    localparam int HOLD_WDOG_BIT  = 3;
    localparam int HOLD_RADIO_BIT = 2;
    localparam int HOLD_SWTIM_BIT = 1;
    localparam int HOLD_WKUP_BIT  = 0;
    localparam int HOLD_W         = 4;
    localparam int SWC_W          = 4;

    // Values after reset
    localparam logic [3:0] HOLD_RST = 4'h0;
    localparam logic       DBG_RST  = 1'b1;
    localparam logic       STAT_RST = 1'b0;

    // AHB encodings that the slave checks
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Register selected by the latched address phase
    typedef enum logic [2:0] {
        SEL_NONE, SEL_CHAR3, SEL_SWC, SEL_REV, SEL_HSET, SEL_HCLR, SEL_DBG, SEL_STAT
    } chid_sel_t;

    // Byte address of a register index; bits above 31 fall away
    function automatic logic [31:0] chid_byte_addr(input logic [31:0] idx);
        chid_byte_addr = {idx[29:0], 2'h0};
    endfunction : chid_byte_addr

    // Address decode, used by the slave at the address phase
    function automatic chid_sel_t chid_decode(input logic [31:0] addr);
        if (addr == chid_byte_addr(CHAR3_IDX))     chid_decode = SEL_CHAR3;
        else if (addr == chid_byte_addr(SWC_IDX))  chid_decode = SEL_SWC;
        else if (addr == chid_byte_addr(REV_IDX))  chid_decode = SEL_REV;
        else if (addr == chid_byte_addr(HSET_IDX)) chid_decode = SEL_HSET;
        else if (addr == chid_byte_addr(HCLR_IDX)) chid_decode = SEL_HCLR;
        else if (addr == chid_byte_addr(DBG_IDX))  chid_decode = SEL_DBG;
        else if (addr == chid_byte_addr(STAT_IDX)) chid_decode = SEL_STAT;
        else                                       chid_decode = SEL_NONE;
    endfunction : chid_decode

endpackage : chid_pkg

// ### design/chid_hold_if.sv
/*
 * Interface between the register front end and the timer hold core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface chid_hold_if;
    logic [3:0] set_req;    // One-cycle write-one-to-hold mask
    logic [3:0] clr_req;    // One-cycle write-one-to-resume mask
    logic       dbg_en;     // Hold everything during a debug halt
    logic       halted;     // CPU halted in debug state
    logic       reset_only; // Watchdog in reset-only mode
    logic [3:0] sw_state;   // Software hold state
    logic [3:0] hold;       // Effective hold to each timer

    modport ctrl (output set_req, clr_req, dbg_en, halted, reset_only, input sw_state, hold);
    modport core (input set_req, clr_req, dbg_en, halted, reset_only, output sw_state, hold);
endinterface : chid_hold_if

// ### design/chid_id_regs.sv
/*
 * Read-only identification bytes, held in registers.
 * Assumes the values are fixed at build time by parameters.
 */
`timescale 1ns/100ps
module chid_id_regs #(
    parameter logic [7:0] CHAR3 = 8'h39, // Arbitrary value
    parameter logic [3:0] SWC   = 4'h0,
    parameter logic [7:0] REV   = 8'h43  // Arbitrary value
) (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Identification bytes
    output      logic [7:0] char3,
    output      logic [7:0] swc,
    output      logic [7:0] rev
);
    typedef struct packed {
        logic [7:0] char3;
        logic [7:0] swc;
        logic [7:0] rev;
    } chid_id_st_t;

    chid_id_st_t st_ff;
    chid_id_st_t nxt_st;

    // Upper nibble of the compatibility byte is reserved and reads zero
    always_comb begin
        nxt_st.char3 = CHAR3;
        nxt_st.swc   = {4'h0, SWC};
        nxt_st.rev   = REV;
    end

    // Values appear one edge after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign char3 = st_ff.char3;
    assign swc   = st_ff.swc;
    assign rev   = st_ff.rev;
endmodule : chid_id_regs

// ### design/chid_hold_core.sv
/*
 * Timer hold core: software hold state and the effective hold per timer.
 * Assumes set and clear masks are one-cycle pulses from the register front end.
 */
`timescale 1ns/100ps
module chid_hold_core (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control and result
    chid_hold_if.core hif
);
    typedef struct packed {
        logic [3:0] sw;
        logic [3:0] hold;
    } chid_core_st_t;

    chid_core_st_t st_ff;
    chid_core_st_t nxt_st;

    // Set wins over clear so that a hold request is never lost
    always_comb begin
        nxt_st.sw = (st_ff.sw & ~hif.clr_req) | hif.set_req;
        nxt_st.hold[chid_pkg::HOLD_WDOG_BIT] = (st_ff.sw[chid_pkg::HOLD_WDOG_BIT] & ~hif.reset_only)
                                             | hif.halted;
        nxt_st.hold[2:0] = st_ff.sw[2:0] | {3{hif.halted & hif.dbg_en}};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= {chid_pkg::HOLD_RST, 4'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hif.sw_state = st_ff.sw;
    assign hif.hold     = st_ff.hold;

    wdog_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.sw[3] && !hif.reset_only |=> hif.hold[3])
        else $error("watchdog hold not applied");
    hold_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hif.set_req != 4'h0 |=> st_ff.sw == ($past(st_ff.sw) & ~$past(hif.clr_req) | $past(hif.set_req)))
        else $error("hold set mask misapplied");
    hold_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hif.clr_req != 4'h0 && hif.set_req == 4'h0 |=> st_ff.sw == ($past(st_ff.sw) & ~$past(hif.clr_req)))
        else $error("hold clear mask misapplied");
    dbg_all_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hif.halted && hif.dbg_en |=> hif.hold == 4'hF)
        else $error("debug halt did not hold all timers");
    dbg_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hif.halted && !hif.dbg_en |=> hif.hold[2:0] == $past(st_ff.sw[2:0]))
        else $error("debug halt hold not following software state");
    dbg_wdog_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hif.halted |=> hif.hold[3])
        else $error("watchdog not held in debug halt");
    rst_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hif.reset_only && !hif.halted |=> !hif.hold[3])
        else $error("software hold reached reset-only watchdog");
endmodule : chid_hold_core

// ### test/chid_regs_bench.sv
/*
 * Self-checking bench for the chip identification and timer hold register group.
 * Assumes a single AHB-Lite master (this bench) and that the slave's hreadyout is the bus hready.
 */
`timescale 1ns/100ps
module chid_regs_bench;

    // Identification values handed to the design; both bytes are arbitrary
    localparam logic [7:0]  CHAR3_V = 8'h39;
    localparam logic [3:0]  SWC_V   = 4'h5;
    localparam logic [7:0]  REV_V   = 8'h43;
    // Byte addresses are four times the register index
    localparam logic [31:0] A_CHAR3 = {chid_pkg::CHAR3_IDX[29:0], 2'h0};
    localparam logic [31:0] A_SWC   = {chid_pkg::SWC_IDX[29:0], 2'h0};
    localparam logic [31:0] A_REV   = {chid_pkg::REV_IDX[29:0], 2'h0};
    localparam logic [31:0] A_SET   = {chid_pkg::HSET_IDX[29:0], 2'h0};
    localparam logic [31:0] A_CLR   = {chid_pkg::HCLR_IDX[29:0], 2'h0};
    localparam logic [31:0] A_DBG   = {chid_pkg::DBG_IDX[29:0], 2'h0};
    localparam logic [31:0] A_STAT  = {chid_pkg::STAT_IDX[29:0], 2'h0};
    localparam logic [31:0] A_NONE  = 32'h4000_CC04;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        wdog_reset_only;
    logic        cpu_debug_halted;
    logic        hold_watchdog;
    logic        hold_radio_master_clock;
    logic        hold_software_timer;
    logic        hold_wakeup_timer;
    logic        debug_halt_hold_enable;
    logic        cal_phase_flag;
    logic [3:0]  hold_vec;
    int          bad_count;
    int          cmp_count;

    // One slave on the bus, so its ready is the bus ready
    assign hready   = hreadyout;
    assign hold_vec = {hold_watchdog, hold_radio_master_clock, hold_software_timer, hold_wakeup_timer};

    chid_regs #(
        .CHAR3_VALUE (CHAR3_V),
        .SWC_VALUE   (SWC_V),
        .REV_VALUE   (REV_V)
    ) dut (
        .hclk                    (hclk),
        .hresetn                 (hresetn),
        .hsel                    (hsel),
        .haddr                   (haddr),
        .htrans                  (htrans),
        .hwrite                  (hwrite),
        .hsize                   (hsize),
        .hwdata                  (hwdata),
        .hready                  (hready),
        .hreadyout               (hreadyout),
        .hresp                   (hresp),
        .hrdata                  (hrdata),
        .wdog_reset_only         (wdog_reset_only),
        .cpu_debug_halted        (cpu_debug_halted),
        .hold_watchdog           (hold_watchdog),
        .hold_radio_master_clock (hold_radio_master_clock),
        .hold_software_timer     (hold_software_timer),
        .hold_wakeup_timer       (hold_wakeup_timer),
        .debug_halt_hold_enable  (debug_halt_hold_enable),
        .cal_phase_flag          (cal_phase_flag)
    );

    // Free-running 125 MHz clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Verdict and end of run, shared by the tests and the watchdog
    task automatic complete_run;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // Single compare for every kind of result, widened to a word
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    // Edges are sampled before the design's own updates land, so no race
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        chk_word({31'h0, hready}, 32'h1);
    endtask : wait_ready

    // One transfer: address phase held until ready, then data phase until ready
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       input logic [2:0] size, output logic [31:0] rdata);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= addr;
        hwrite <= wr;
        hsize  <= size;
        wait_ready;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        wait_ready;
        rdata = hrdata;
        chk_word({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic reg_wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] rd;
        bus(1'b1, addr, data, chid_pkg::HSIZE_WORD, rd);
    endtask : reg_wr

    task automatic reg_chk(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, addr, 32'h0, chid_pkg::HSIZE_WORD, rd);
        chk_word(rd, exp);
    endtask : reg_chk

    // Hold outputs lag their causes by a fixed edge or two; three edges covers both
    task automatic chk_hold(input logic [3:0] exp);
        repeat (3) @(posedge hclk);
        chk_word({28'h0, hold_vec}, {28'h0, exp});
    endtask : chk_hold

    task automatic set_in(input logic ro, input logic halted);
        @(posedge hclk);
        wdog_reset_only  <= ro;
        cpu_debug_halted <= halted;
    endtask : set_in

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge hclk);
        bad_count++;
        complete_run;
    end

    // Test sequence
    initial begin
        logic [31:0] rd;
        logic [3:0]  e;
        logic [31:0] id_a [3];
        logic [31:0] id_v [3];
        id_a = '{A_CHAR3, A_SWC, A_REV};
        id_v = '{{24'h0, CHAR3_V}, {28'h0, SWC_V}, {24'h0, REV_V}};
        e = 4'h0;
        bad_count = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = chid_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        wdog_reset_only = 1'b0;
        cpu_debug_halted = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        chk_word({30'h0, debug_halt_hold_enable, cal_phase_flag}, 32'h2);
        chk_hold(4'h0);
        reg_chk(A_SET, 32'h0);
        reg_chk(A_CLR, 32'h0);
        reg_chk(A_DBG, 32'h1);
        reg_chk(A_STAT, 32'h0);
        // Identification bytes read back and ignore writes; reserved nibble reads zero
        for (int i = 0; i < 3; i++) begin
            reg_chk(id_a[i], id_v[i]);
            reg_wr(id_a[i], 32'hFFFF_FFFF);
            reg_chk(id_a[i], id_v[i]);
        end
        // Unmapped place: write ignored, read zero
        reg_wr(A_NONE, 32'hFFFF_FFFF);
        reg_chk(A_NONE, 32'h0);
        // Set one bit at a time; the zeros must leave earlier holds alone
        for (int i = 0; i < 4; i++) begin
            reg_wr(A_SET, 32'h1 << i);
            e = e | (4'h1 << i);
            reg_chk(A_SET, {28'h0, e});
            chk_hold(e);
        end
        // Clear one bit at a time
        for (int i = 0; i < 4; i++) begin
            reg_wr(A_CLR, 32'h1 << i);
            e = e & ~(4'h1 << i);
            reg_chk(A_CLR, {28'h0, e});
            chk_hold(e);
        end
        // A byte-sized write is not taken at all
        bus(1'b1, A_SET, 32'hF, 3'h0, rd);
        reg_chk(A_SET, 32'h0);
        // Reset-only watchdog ignores the software hold
        reg_wr(A_SET, 32'hF);
        set_in(1'b1, 1'b0);
        chk_hold(4'h7);
        set_in(1'b0, 1'b0);
        chk_hold(4'hF);
        // Debug halt with the enable at its reset value holds everything
        reg_wr(A_CLR, 32'hF);
        set_in(1'b1, 1'b1);
        chk_hold(4'hF);
        // Enable low: only the watchdog is forced, the rest follow software
        reg_wr(A_DBG, 32'h0);
        reg_chk(A_DBG, 32'h0);
        set_in(1'b0, 1'b1);
        chk_hold(4'h8);
        reg_wr(A_SET, 32'h5);
        chk_hold(4'hD);
        set_in(1'b1, 1'b1);
        chk_hold(4'hD);
        set_in(1'b0, 1'b0);
        chk_hold(4'h5);
        // Calibration flag and debug enable: only bit 0 is writable
        reg_wr(A_STAT, 32'hFFFF_FFFF);
        reg_chk(A_STAT, 32'h1);
        chk_word({30'h0, debug_halt_hold_enable, cal_phase_flag}, 32'h1);
        reg_wr(A_STAT, 32'h0);
        reg_chk(A_STAT, 32'h0);
        reg_wr(A_DBG, 32'hFFFF_FFFF);
        reg_chk(A_DBG, 32'h1);
        // Second reset in mid-run brings back every reset value
        reg_wr(A_STAT, 32'h1);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk_word({30'h0, debug_halt_hold_enable, cal_phase_flag}, 32'h2);
        chk_hold(4'h0);
        reg_chk(A_SET, 32'h0);
        complete_run;
    end

endmodule : chid_regs_bench
